// file: sbc_interrupt_pulse_logic.sv
// Interrupt pulse generator, status latches and configuration sense pin.
//
// How it works
// - In normal or stop mode an event drives the pin low for 100 us.
// - The pin then stays high at least 100 us before the next pulse.
// - Pulses never change the operating mode; mode is only an input here.
// - Global select bit, reset 0 for wake-only, 1 adds failure interrupts.
// - Wake class: wake events interrupt at once only when enabled as wake source.
// - Global class adds failure interrupts; live wake levels never interrupt.
// - Mode-forcing errors, power-on and device status bits never interrupt.
// - Entering stop mode with any wake status bit still set interrupts.
// - Wake and failure status registers update at each falling edge of the pulse.
// - Events stay latched until the host clears them; live levels are not latched.
// - Push-pull output drives both levels; low means interrupt.
// - In init mode the pin is an input selecting the hardware configuration.
// - The sensed configuration level passes a 10 us filter first.
// - Global class pulses and status updates time exactly like the wake class.
`timescale 1ns/100ps
`include "irq_pulse_regs.svh"

module sbc_interrupt_pulse_logic #(
    parameter int WAKE1_W   = 8,
    parameter int WAKE2_W   = 8,
    parameter int FAIL_W    = 16,
    parameter int EXCL_W    = 8,
    parameter int LEVEL_W   = 8,
    parameter int CNT_W     = 16,
    parameter int PULSE_CYC = `IRQ_PULSE_CYC,
    parameter int GAP_CYC   = `IRQ_MIN_GAP_CYC,
    parameter int FILT_CYC  = `CFG_FILTER_CYC
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Operating mode and stop command.
    input  wire irq_pulse_pkg::mode_t  op_mode,
    input  wire logic                  stop_cmd,
    // Class select configuration.
    input  wire logic                  cfg_write,
    input  wire logic                  int_global_value,
    output logic                       int_global,
    // Event sources as one-cycle pulses per bit, wake enables and live wake levels.
    input  wire logic [WAKE1_W-1:0]    wake_event_first,
    input  wire logic [WAKE1_W-1:0]    wake_enable_first,
    input  wire logic [WAKE2_W-1:0]    wake_event_second,
    input  wire logic [WAKE2_W-1:0]    wake_enable_second,
    input  wire logic [FAIL_W-1:0]     fail_event,
    input  wire logic [EXCL_W-1:0]     excluded_event,
    input  wire logic [LEVEL_W-1:0]    wake_level_live,
    // Host clear strobes.
    input  wire logic                  clear_first,
    input  wire logic                  clear_second,
    input  wire logic                  clear_fail,
    input  wire logic                  clear_excluded,
    // Status seen by the host.
    output logic [WAKE1_W-1:0]         wake_status_first,
    output logic [WAKE2_W-1:0]         wake_status_second,
    output logic [FAIL_W-1:0]          fail_status,
    output logic [EXCL_W-1:0]          excluded_status,
    output logic [LEVEL_W-1:0]         wake_level_view,
    output logic                       irq_pending,
    // Interrupt pin.
    input  wire logic                  int_in,
    output logic                       int_out,
    output logic                       int_oe,
    // Sensed hardware configuration.
    output logic                       cfg_level,
    output logic                       cfg_valid
);

    import irq_pulse_pkg::*;

    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST   = CNT_W'(GAP_CYC - 1);

    function automatic logic is_active(input mode_t m);
        is_active = (m == MODE_NORMAL) || (m == MODE_STOP);
    endfunction

    irq_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic [WAKE1_W-1:0] latch_first;
    logic [WAKE2_W-1:0] latch_second;
    logic [FAIL_W-1:0]  latch_fail;
    logic               wake_trig;
    logic               fail_trig;
    logic               stop_trig;
    logic               irq_trig;
    logic               launch;
    logic               int_sync1;
    logic               int_sync2;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources.
    always_comb begin
        wake_trig = |(wake_event_first & wake_enable_first)
                  | |(wake_event_second & wake_enable_second);
        fail_trig = int_global && (|fail_event);
        stop_trig = stop_cmd && (|latch_first || |latch_second);
        // Excluded events and live wake levels are deliberately not sources.
        irq_trig  = is_active(op_mode) && (wake_trig || fail_trig || stop_trig);
        launch    = (state == ST_IDLE) && irq_pending && is_active(op_mode);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_global <= `IRQ_GLOBAL_RST;
        end else if (cfg_write) begin
            int_global <= int_global_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending request; a new event wins over the launch that consumes it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_pending <= 1'b0;
        end else if (irq_trig) begin
            irq_pending <= 1'b1;
        end else if (launch) begin
            irq_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse and minimum-gap sequencer.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launch) begin
                        state <= ST_PULSE;
                        cnt   <= PULSE_LAST;
                    end
                end
                ST_PULSE: begin
                    if (cnt == '0) begin
                        state <= ST_GAP;
                        cnt   <= GAP_LAST;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                ST_GAP: begin
                    if (cnt == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    cnt   <= '0;
                end
            endcase
        end
    end

    // The pin is driven in every mode but init, where it must float for sensing.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_out <= `IRQ_PIN_RST;
            int_oe  <= 1'b0;
        end else begin
            int_oe <= (op_mode != MODE_INIT);
            if (launch) begin
                int_out <= 1'b0;
            end else if (state == ST_PULSE && cnt == '0) begin
                int_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal latches collect events at once; a clear removes only the bits
    // the host has seen, and a set in the same cycle survives the clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_first <= '0;
        end else begin
            latch_first <= (latch_first & ~(clear_first ? wake_status_first : '0))
                         | wake_event_first;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_second <= '0;
        end else begin
            latch_second <= (latch_second & ~(clear_second ? wake_status_second : '0))
                          | wake_event_second;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_fail <= '0;
        end else begin
            latch_fail <= (latch_fail & ~(clear_fail ? fail_status : '0))
                        | fail_event;
        end
    end

    // Host-visible copies take the latches only when a pulse starts and a host clear zeroes them, so the
    // host never sees a status bit set that was not announced by a falling edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_status_first  <= '0;
            wake_status_second <= '0;
            fail_status        <= '0;
        end else if (launch) begin
            wake_status_first  <= latch_first;
            wake_status_second <= latch_second;
            fail_status        <= latch_fail;
        end else begin
            if (clear_first) begin
                wake_status_first <= '0;
            end
            if (clear_second) begin
                wake_status_second <= '0;
            end
            if (clear_fail) begin
                fail_status <= '0;
            end
        end
    end

    // Mode-forcing errors are reported without a pulse, so they show at once.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            excluded_status <= '0;
        end else begin
            excluded_status <= (excluded_status & ~(clear_excluded ? excluded_status : '0))
                             | excluded_event;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_level_view <= '0;
        end else begin
            wake_level_view <= wake_level_live;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration sense path.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_sync1 <= 1'b0;
            int_sync2 <= 1'b0;
        end else begin
            int_sync1 <= int_in;
            int_sync2 <= int_sync1;
        end
    end

    cfg_select_filter #(
        .FILT_CYC (FILT_CYC),
        .CNT_W    (CNT_W)
    ) u_cfg_filter (
        .clk       (clk),
        .resetn    (resetn),
        .sense_en  (op_mode == MODE_INIT),
        .level_in  (int_sync2),
        .cfg_level (cfg_level),
        .cfg_valid (cfg_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helper counters for pulse and gap checks.
    logic [CNT_W-1:0] low_len;
    logic [CNT_W-1:0] high_len;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_len  <= '0;
            high_len <= GAP_LAST;
        end else begin
            low_len  <= int_out ? '0 : low_len + CNT_W'(1);
            high_len <= !int_out ? '0 : (high_len == GAP_LAST ? high_len
                                                              : high_len + CNT_W'(1));
        end
    end

    sequence s_launch;
        state == ST_IDLE && irq_pending && is_active(op_mode);
    endsequence

    sequence s_pin_low;
        !int_out && state == ST_PULSE;
    endsequence

    a_pulse_width: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(int_out) |-> $past(low_len) == PULSE_LAST)
        else $error("interrupt pulse width wrong");

    a_gap_min: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(int_out) |-> $past(high_len) == GAP_LAST)
        else $error("interrupt high time too short");

    a_launch_low: assert property (
        @(posedge clk) disable iff (!resetn)
        s_launch |=> s_pin_low)
        else $error("pulse did not start after launch");

    a_trigger_pending: assert property (
        @(posedge clk) disable iff (!resetn)
        irq_trig |=> irq_pending)
        else $error("interrupt event lost");

    a_no_spurious: assert property (
        @(posedge clk) disable iff (!resetn)
        (!irq_trig && !irq_pending) |=> !irq_pending)
        else $error("pending raised without a source");

    a_global_fail: assert property (
        @(posedge clk) disable iff (!resetn)
        (is_active(op_mode) && int_global && |fail_event) |-> irq_trig)
        else $error("global class failure did not interrupt");

    a_wake_only: assert property (
        @(posedge clk) disable iff (!resetn)
        (!int_global && !wake_trig && !stop_trig) |-> !irq_trig)
        else $error("wake class interrupted on a failure");

    a_stop_wake: assert property (
        @(posedge clk) disable iff (!resetn)
        (is_active(op_mode) && stop_cmd && (|latch_first || |latch_second)) |-> irq_trig)
        else $error("stop entry with wake status did not interrupt");

    a_view_update: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(int_out) |-> wake_status_first == $past(latch_first)
                           && fail_status == $past(latch_fail))
        else $error("status not updated at falling edge");

    a_latch_hold: assert property (
        @(posedge clk) disable iff (!resetn)
        ($past(latch_first) & ~latch_first) != '0 |-> $past(clear_first))
        else $error("wake status dropped without a clear");

    a_init_float: assert property (
        @(posedge clk) disable iff (!resetn)
        op_mode == MODE_INIT |=> !int_oe)
        else $error("pin driven during init");

    a_push_pull: assert property (
        @(posedge clk) disable iff (!resetn)
        op_mode != MODE_INIT |=> int_oe)
        else $error("pin not driven outside init");

endmodule // sbc_interrupt_pulse_logic

// file: irq_pulse_regs.svh
// Timing counts and reset values for the interrupt pulse logic.
`ifndef IRQ_PULSE_REGS_SVH
`define IRQ_PULSE_REGS_SVH

`define IRQ_CLK_PERIOD_NS 5
`define IRQ_PULSE_NS      100000
`define IRQ_PULSE_CYC     ((`IRQ_PULSE_NS + `IRQ_CLK_PERIOD_NS - 1) / `IRQ_CLK_PERIOD_NS)
`define IRQ_MIN_GAP_NS    100000
`define IRQ_MIN_GAP_CYC   ((`IRQ_MIN_GAP_NS + `IRQ_CLK_PERIOD_NS - 1) / `IRQ_CLK_PERIOD_NS)
`define CFG_FILTER_NS     10000
`define CFG_FILTER_CYC    ((`CFG_FILTER_NS + `IRQ_CLK_PERIOD_NS - 1) / `IRQ_CLK_PERIOD_NS)
`define IRQ_GLOBAL_RST    1'b0
`define IRQ_PIN_RST       1'b1

`endif

// file: irq_pulse_pkg.sv
// Types shared by the interrupt pulse logic.
package irq_pulse_pkg;

    typedef enum logic [2:0] {
        MODE_INIT      = 3'h0,
        MODE_NORMAL    = 3'h1,
        MODE_STOP      = 3'h2,
        MODE_SLEEP     = 3'h3,
        MODE_RESTART   = 3'h4,
        MODE_FAIL_SAFE = 3'h5
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_PULSE = 2'h1,
        ST_GAP   = 2'h2
    } irq_state_t;

endpackage

// file: cfg_select_filter.sv
// Glitch filter for the configuration level sensed on the interrupt pin.
`timescale 1ns/100ps
`include "irq_pulse_regs.svh"

module cfg_select_filter #(
    parameter int FILT_CYC = `CFG_FILTER_CYC,
    parameter int CNT_W    = 16
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Sense control and synchronised level.
    input  wire logic sense_en,
    input  wire logic level_in,
    // Accepted configuration.
    output logic      cfg_level,
    output logic      cfg_valid
);

    localparam logic [CNT_W-1:0] LAST = CNT_W'(FILT_CYC - 1);

    logic             last_level;
    logic [CNT_W-1:0] stable_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // A level is accepted only once it has held for the whole filter time.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_level <= 1'b0;
            stable_cnt <= '0;
        end else begin
            last_level <= level_in;
            if (!sense_en || level_in != last_level) begin
                stable_cnt <= '0;
            end else if (stable_cnt != LAST) begin
                stable_cnt <= stable_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_level <= 1'b0;
            cfg_valid <= 1'b0;
        end else if (sense_en && stable_cnt == LAST && level_in == last_level) begin
            cfg_level <= last_level;
            cfg_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_cfg_filtered: assert property (
        @(posedge clk) disable iff (!resetn)
        ($rose(cfg_valid) || $changed(cfg_level)) |-> $past(stable_cnt) == LAST)
        else $error("configuration level accepted before the filter time");

endmodule // cfg_select_filter

// file: host_model.sv
// Host side of the interrupt pin: level resolution and pulse timing.
`timescale 1ns/100ps

module host_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Device pin drive and host config level.
    input  wire logic int_out,
    input  wire logic int_oe,
    input  wire logic cfg_drv,
    // Pin level and measurements.
    output logic      pin,
    output int        cnt,
    output int        low_len,
    output int        gap_len
);
    logic prev;
    int   run_len;

    // The host drives the strap level only while the device is not driving.
    assign pin = int_oe ? int_out : cfg_drv;

    // A rise closes a low run and every counted fall after the first closes a high gap.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev    <= 1'b1;
            run_len <= 0;
            cnt     <= 0;
            low_len <= 0;
            gap_len <= 0;
        end else if (pin !== prev) begin
            prev    <= pin;
            run_len <= 1;
            if (prev === 1'b0) begin
                low_len <= run_len;
            end else if (int_oe === 1'b1) begin
                cnt <= cnt + 1;
                if (cnt > 0) begin
                    gap_len <= run_len;
                end
            end
        end else begin
            run_len <= run_len + 1;
        end
    end
endmodule // host_model

// file: sbc_interrupt_pulse_logic_tb_top.sv
// Testbench for the interrupt pulse logic.
`timescale 1ns/100ps

module sbc_interrupt_pulse_logic_tb_top;
    import irq_pulse_pkg::*;
    localparam int PW = 8;
    localparam int GW = 8;
    localparam int FW = 4;
    logic        clk;
    logic        resetn;
    mode_t       op_mode;
    logic        stop_cmd, cfg_write, int_global_value, int_global;
    logic        clear_first, clear_second, clear_fail, clear_excluded;
    logic [7:0]  wake_event_first, wake_enable_first, wake_status_first;
    logic [7:0]  wake_event_second, wake_enable_second, wake_status_second;
    logic [15:0] fail_event, fail_status;
    logic [7:0]  excluded_event, excluded_status, wake_level_live, wake_level_view;
    logic        irq_pending, int_out, int_oe, cfg_level, cfg_valid, cfg_drv, pin;
    int          cnt, low_len, gap_len, c, n_errors, checks_done;

    always #2.5 clk = ~clk;

    sbc_interrupt_pulse_logic #(.PULSE_CYC(PW), .GAP_CYC(GW), .FILT_CYC(FW)) dut (
        .clk, .resetn, .op_mode, .stop_cmd, .cfg_write, .int_global_value,
        .int_global, .wake_event_first, .wake_enable_first, .wake_event_second,
        .wake_enable_second, .fail_event, .excluded_event, .wake_level_live,
        .clear_first, .clear_second, .clear_fail, .clear_excluded,
        .wake_status_first, .wake_status_second, .fail_status, .excluded_status,
        .wake_level_view, .irq_pending, .int_in(pin), .int_out, .int_oe,
        .cfg_level, .cfg_valid
    );

    host_model hm (
        .clk, .resetn, .int_out, .int_oe, .cfg_drv, .pin, .cnt, .low_len, .gap_len
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic run(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Event, clear and config-write strobes are one cycle wide, so one task serves them all.
    task automatic fire(input int k, input logic [15:0] v);
        case (k)
            0: wake_event_first = v[7:0];
            1: wake_event_second = v[7:0];
            2: fail_event = v;
            3: excluded_event = v[7:0];
            4: {cfg_write, int_global_value} = {1'b1, v[0]};
            5: clear_first = 1'b1;
            6: clear_second = 1'b1;
            7: clear_fail = 1'b1;
            default: clear_excluded = 1'b1;
        endcase
        run(1);
        {wake_event_first, wake_event_second, fail_event, excluded_event} = '0;
        {cfg_write, clear_first, clear_second, clear_fail, clear_excluded} = '0;
    endtask

    // Bounded wait; a hang is reported as a mismatch and ends the run.
    task automatic wait_cnt(input int n);
        for (int i = 0; i < 200 && cnt < n; i++) begin
            @(negedge clk);
        end
        if (cnt < n) begin
            chk(cnt, n);
            print_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, resetn, cfg_drv, stop_cmd, int_global_value} = '0;
        op_mode = MODE_INIT;
        {wake_enable_first, wake_enable_second, wake_level_live} = '0;
        {wake_event_first, wake_event_second, fail_event, excluded_event} = '0;
        {cfg_write, clear_first, clear_second, clear_fail, clear_excluded} = '0;
        {n_errors, checks_done} = '0;
        run(12);
        resetn = 1'b1;
        chk(int_out, 1'b1);
        chk(int_oe, 1'b0);
        chk(int_global, 1'b0);
        cfg_drv = 1'b1;
        run(2);
        cfg_drv = 1'b0;
        run(3);
        chk(cfg_valid, 1'b0);
        cfg_drv = 1'b1;
        run(16);
        chk(cfg_valid, 1'b1);
        chk(cfg_level, 1'b1);
        $display("test config finished");
        op_mode = MODE_NORMAL;
        cfg_drv = 1'b0;
        run(2);
        chk(pin, 1'b1);
        {wake_enable_first, wake_enable_second} = {8'h01, 8'h01};
        fire(0, 16'h0001);
        wait_cnt(1);
        fire(1, 16'h0001);
        chk(irq_pending, 1'b1);
        wait_cnt(2);
        run(PW + 2);
        chk(low_len, PW);
        chk(gap_len >= GW + 1, 1'b1);
        chk(wake_status_first, 8'h01);
        chk(wake_status_second, 8'h01);
        $display("test pulse finished");
        c = cnt;
        fire(2, 16'h0001);
        run(30);
        chk(cnt, c);
        fire(4, 16'h0001);
        run(2);
        chk(int_global, 1'b1);
        run(30);
        c = cnt;
        fire(2, 16'h0002);
        wait_cnt(c + 1);
        run(PW + 2);
        chk(fail_status[1], 1'b1);
        chk(low_len, PW);
        c = cnt;
        fire(3, 16'h0001);
        wake_level_live = 8'hFF;
        run(30);
        chk(cnt, c);
        chk(excluded_status[0], 1'b1);
        chk(wake_level_view, 8'hFF);
        wake_level_live = 8'h00;
        run(2);
        chk(wake_level_view, 8'h00);
        $display("test class finished");
        fire(5, 16'h0000);
        chk(wake_status_first, 8'h00);
        chk(wake_status_second, 8'h01);
        run(2);
        chk(wake_status_first, 8'h00);
        fire(6, 16'h0000);
        chk(wake_status_second, 8'h00);
        fire(7, 16'h0000);
        chk(fail_status[1], 1'b0);
        fire(8, 16'h0000);
        chk(excluded_status, 8'h00);
        $display("test clear finished");
        wake_enable_first = 8'h00;
        c = cnt;
        fire(0, 16'h0004);
        run(30);
        chk(cnt, c);
        stop_cmd = 1'b1;
        op_mode = MODE_STOP;
        run(1);
        stop_cmd = 1'b0;
        wait_cnt(c + 1);
        run(2);
        chk(wake_status_first[2], 1'b1);
        $display("test stop finished");
        // Sleep mode must latch a wake event silently, even when it is enabled.
        op_mode = MODE_SLEEP;
        c = cnt;
        wake_enable_first = 8'h01;
        fire(0, 16'h0001);
        run(40);
        chk(cnt, c);
        chk(irq_pending, 1'b0);
        $display("test sleep finished");
        print_verdict();
    end
endmodule // sbc_interrupt_pulse_logic_tb_top
